// *** rtl/cdc_pkg.sv ***
// package of constants and types for the configuration done and chain handshake block
// How it works
// - hold load complete flag low before and during configuration
// - release the flag once the last data unit is taken without error, before initialization starts
// - sense the flag line; when high, initialize then enter user mode
// - after initialization, external low drive on the flag is ignored
// - configuration accepted only while chain enable input is low
// - drive chain enable output low in user mode while chain enable input is low
// - in active serial mode drive command output to the serial memory
// - in active serial mode drive memory select; otherwise pin is user I/O
// - on configuration error pull the error status line low
// - external low on error line during load or init forces error state
// - reconfig request low in user mode resets; rising edge restarts load
// - in active serial mode drive the load clock output
package cdc_pkg;
  // load clock divider: 200 MHz / (2 * 5) = 20 MHz
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned LOAD_CLK_NS     = 50;
  localparam int unsigned LOAD_HALF_CYC   = LOAD_CLK_NS / (2 * CLK_PERIOD_NS);
  // cycles spent in initialization after the flag line reads high
  localparam int unsigned INIT_CYCLES     = 16;
  // serial memory read command, sent msb first
  localparam logic [7:0]  FLASH_READ_CMD  = 8'h03;
  localparam logic [3:0]  CMD_BITS        = 4'h8;

  typedef enum logic [2:0] {
    CDC_RESET  = 3'b000,
    CDC_LOAD   = 3'b001,
    CDC_WAITHI = 3'b010,
    CDC_INIT   = 3'b011,
    CDC_USER   = 3'b100,
    CDC_ERROR  = 3'b101
  } cdc_state_type;
endpackage

// *** rtl/cdc_clk_div.sv ***
// divider producing a one-cycle enable at each load clock half period
`timescale 1ns/1ps
module cdc_clk_div #(
  parameter int unsigned HALF = 5
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  logic [7:0] cnt_reg;
  wire        wrap = (cnt_reg == 8'(HALF - 1));

  // count while running, pulse on wrap
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
      tick    <= wrap;
    end
  end
endmodule

// *** rtl/cdc_done_chain.sv ***
// configuration done flag, chain enable and serial memory control
`timescale 1ns/1ps
module cdc_done_chain (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic reconfig_request_n,
  input  wire logic chain_enable_in_n,
  input  wire logic active_serial_mode,
  input  wire logic data_valid,
  input  wire logic data_last,
  input  wire logic data_error,
  input  wire logic load_complete_flag_in,
  input  wire logic config_error_n_in,
  output logic      load_complete_flag_out,
  output logic      load_complete_flag_oe,
  output logic      config_error_n_out,
  output logic      config_error_n_oe,
  output logic      chain_enable_out_n,
  output logic      flash_command_out,
  output logic      flash_select_n,
  output logic      flash_pins_oe,
  output logic      load_clock,
  output logic      load_clock_oe,
  output logic      data_accept,
  output logic      user_mode,
  output logic      io_tristate
);
  import cdc_pkg::*;

  cdc_state_type state_reg;
  cdc_state_type state_next;
  logic          req_d_reg;
  logic [7:0]    init_cnt_reg;
  logic [3:0]    bit_cnt_reg;
  logic [7:0]    cmd_sh_reg;
  logic          lclk_reg;
  logic          tick;

  // decode of the current phase
  wire loading    = (state_reg == CDC_LOAD);
  wire in_init    = (state_reg == CDC_INIT);
  wire in_user    = (state_reg == CDC_USER);
  wire enabled    = !chain_enable_in_n;
  wire take_data  = loading && enabled && data_valid;
  wire in_waithi  = (state_reg == CDC_WAITHI);
  // an outside low on the error line only counts while loading, waiting for the flag line or initializing
  wire ext_err    = !config_error_n_in && (loading || in_waithi || in_init);
  wire req_rise   = reconfig_request_n && !req_d_reg;
  wire as_run     = loading && enabled && active_serial_mode;
  wire falling    = tick && lclk_reg;
  wire cmd_done   = (bit_cnt_reg == CMD_BITS);

  cdc_clk_div #(.HALF(LOAD_HALF_CYC)) u_div (
    .mclk (mclk),
    .rst  (rst),
    .run  (as_run),
    .tick (tick)
  );

  // next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CDC_RESET: begin
        if (req_rise) begin
          state_next = CDC_LOAD;
        end
      end
      CDC_LOAD: begin
        if (take_data && data_error) begin
          state_next = CDC_ERROR;
        end else if (take_data && data_last) begin
          state_next = CDC_WAITHI;
        end
      end
      CDC_WAITHI: begin
        if (load_complete_flag_in) begin
          state_next = CDC_INIT;
        end
      end
      CDC_INIT: begin
        if (init_cnt_reg == 8'(INIT_CYCLES - 1)) begin
          state_next = CDC_USER;
        end
      end
      CDC_USER: begin
        state_next = CDC_USER;
      end
      CDC_ERROR: begin
        state_next = CDC_ERROR;
      end
      default: state_next = CDC_RESET;
    endcase
    if (ext_err && state_next != CDC_ERROR) begin
      state_next = CDC_ERROR;
    end
    if (!reconfig_request_n) begin
      state_next = CDC_RESET;
    end
  end

  // phase register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= CDC_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // reconfig request history; resets low so a high request at release starts a load
  always_ff @(posedge mclk) begin
    if (rst) begin
      req_d_reg <= 1'b0;
    end else begin
      req_d_reg <= reconfig_request_n;
    end
  end

  // initialization counter
  always_ff @(posedge mclk) begin
    if (rst || !in_init) begin
      init_cnt_reg <= 8'h00;
    end else begin
      init_cnt_reg <= init_cnt_reg + 8'h01;
    end
  end

  // load clock and read command shifter for the serial memory
  always_ff @(posedge mclk) begin
    if (rst || !as_run) begin
      lclk_reg    <= 1'b0;
      bit_cnt_reg <= 4'h0;
      cmd_sh_reg  <= FLASH_READ_CMD;
    end else if (tick) begin
      lclk_reg <= !lclk_reg;
      if (falling && !cmd_done) begin
        cmd_sh_reg  <= {cmd_sh_reg[6:0], 1'b0};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // decode of the phase that the next edge enters
  wire next_reset   = (state_next == CDC_RESET);
  wire next_load    = (state_next == CDC_LOAD);
  wire next_error   = (state_next == CDC_ERROR);
  wire next_user    = (state_next == CDC_USER);

  // next values of the pins; taken from the next phase so pins move with the state
  wire flag_oe_next = next_reset || next_load || next_error;
  wire err_oe_next  = next_error || (next_reset && !reconfig_request_n);
  wire chain_next   = !(next_user && enabled);
  wire pins_oe_next = active_serial_mode && !next_user;
  wire select_next  = !(as_run && next_load);
  wire cmd_bit_next = cmd_done ? 1'b1 : cmd_sh_reg[7];
  wire accept_next  = next_load && enabled;

  // open-drain load complete flag: low until all data is in
  always_ff @(posedge mclk) begin
    if (rst) begin
      load_complete_flag_out <= 1'b0;
      load_complete_flag_oe  <= 1'b1;
    end else begin
      load_complete_flag_out <= 1'b0;
      load_complete_flag_oe  <= flag_oe_next;
    end
  end

  // open-drain error line: pulled low in error and while reconfig is held low
  always_ff @(posedge mclk) begin
    if (rst) begin
      config_error_n_out <= 1'b0;
      config_error_n_oe  <= 1'b1;
    end else begin
      config_error_n_out <= 1'b0;
      config_error_n_oe  <= err_oe_next;
    end
  end

  // chain enable towards the next device
  always_ff @(posedge mclk) begin
    if (rst) begin
      chain_enable_out_n <= 1'b1;
    end else begin
      chain_enable_out_n <= chain_next;
    end
  end

  // serial memory command and select pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_command_out <= 1'b0;
      flash_select_n    <= 1'b1;
      flash_pins_oe     <= 1'b0;
    end else begin
      flash_command_out <= cmd_bit_next;
      flash_select_n    <= select_next;
      flash_pins_oe     <= pins_oe_next;
    end
  end

  // load clock pin; delayed like the command so both move on the same edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      load_clock    <= 1'b0;
      load_clock_oe <= 1'b0;
    end else begin
      load_clock    <= lclk_reg;
      load_clock_oe <= pins_oe_next;
    end
  end

  // status towards the core: data accept, user mode, i/o release
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_accept <= 1'b0;
      user_mode   <= 1'b0;
      io_tristate <= 1'b1;
    end else begin
      data_accept <= accept_next;
      user_mode   <= next_user;
      io_tristate <= !next_user;
    end
  end
endmodule

// *** verification/cdc_done_chain_properties.sv ***
// assertions on the done flag, chain enable and serial memory pins
`timescale 1ns/1ps
module cdc_done_chain_props (
  input wire logic mclk, rst, reconfig_request_n, chain_enable_in_n, active_serial_mode,
  input wire logic data_valid, data_last, data_error, config_error_n_in, data_accept,
  input wire logic load_complete_flag_oe, config_error_n_oe, chain_enable_out_n,
  input wire logic flash_select_n, flash_pins_oe, user_mode, io_tristate
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // a last unit that arrived clean one edge ago
  sequence s_clean_end;
    $past(data_valid && data_last && !data_error);
  endsequence
  AST_FLAG_RELEASE: assert property ($fell(load_complete_flag_oe) |-> s_clean_end)
    else $error("flag released early");
  AST_INIT_TIME: assert property (
    $rose(user_mode) |-> $past(load_complete_flag_oe, 16) == 1'b0)
    else $error("init too short");
  AST_USER_KEPT: assert property (user_mode && reconfig_request_n |=> user_mode)
    else $error("user mode lost");
  AST_NO_LOAD: assert property (chain_enable_in_n [*2] |=> !data_accept)
    else $error("data taken while disabled");
  AST_CHAIN_LOW: assert property (
    user_mode && !chain_enable_in_n |=> !user_mode || !chain_enable_out_n)
    else $error("chain output not low");
  AST_CHAIN_IDLE: assert property (chain_enable_in_n |=> chain_enable_out_n)
    else $error("chain output low while disabled");
  AST_SELECT: assert property (
    !flash_select_n |-> flash_pins_oe && $past(active_serial_mode))
    else $error("select without serial mode");
  AST_ERR_UNIT: assert property (
    data_valid && data_error && data_accept && !chain_enable_in_n && reconfig_request_n
    |=> config_error_n_oe)
    else $error("error unit not flagged");
  AST_ERR_LINE: assert property (
    data_accept && !config_error_n_in && reconfig_request_n
    |=> !user_mode && config_error_n_oe)
    else $error("error line ignored");
  AST_RECONFIG: assert property (
    !reconfig_request_n |=> io_tristate && load_complete_flag_oe)
    else $error("reconfig not obeyed");
endmodule

// *** verification/cdc_line_model.sv ***
// open-drain flag and error lines with pull-ups and an outside pull-down
`timescale 1ns/1ps
module cdc_line_model (
  input wire logic load_complete_flag_oe, config_error_n_oe, ext_flag_low, ext_error_low,
  output logic     load_complete_flag_in, config_error_n_in
);
  // a released line returns high through its pull-up
  assign load_complete_flag_in = !(load_complete_flag_oe || ext_flag_low);
  assign config_error_n_in = !(config_error_n_oe || ext_error_low);
endmodule

// *** verification/config_done_chain_handshake_bench.sv ***
// bench for the done flag and chain handshake block
`timescale 1ns/1ps
module config_done_chain_handshake_bench;
  import cdc_pkg::*;
  logic mclk, rst, reconfig_request_n, chain_enable_in_n, active_serial_mode, data_valid;
  logic data_last, data_error, load_complete_flag_in, config_error_n_in, load_complete_flag_out;
  logic load_complete_flag_oe, config_error_n_out, config_error_n_oe, chain_enable_out_n;
  logic flash_command_out, flash_select_n, flash_pins_oe, load_clock, load_clock_oe;
  logic data_accept, user_mode, io_tristate, ext_flag_low, ext_error_low;
  int   n_fail = 0, n_checks = 0, cyc = 0;
  cdc_done_chain uut (.*);
  cdc_line_model u_lines (.*);
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  // cut a hang short
  always @(posedge mclk) if (++cyc > 3000) begin
    n_fail++;
    print_verdict();
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask
  // reconfig pulse then n back to back units, optionally the last one bad
  task automatic load(int n, logic err);
    reconfig_request_n = 0;
    tick(2);
    check(io_tristate, 1);
    reconfig_request_n = 1;
    tick(3);
    check(load_complete_flag_oe, 1);
    check(data_accept, !chain_enable_in_n);
    check(flash_select_n, !(active_serial_mode && !chain_enable_in_n));
    for (int i = 0; i < n; i++) begin
      data_valid = 1;
      data_last = (i == n - 1);
      data_error = err && (i == n - 1);
      tick(1);
    end
    data_valid = 0;
    data_last = 0;
    data_error = 0;
  endtask
  task automatic t_normal();
    active_serial_mode = 1;
    load(4, 0);
    tick(1);
    check(load_complete_flag_oe, 0);
    check(load_complete_flag_out, 0);
    tick(20);
    check(user_mode, 1);
    check(chain_enable_out_n, 0);
    ext_flag_low = 1;
    ext_error_low = 1;
    tick(4);
    check(user_mode, 1);
    ext_flag_low = 0;
    ext_error_low = 0;
    chain_enable_in_n = 1;
    tick(2);
    check(chain_enable_out_n, 1);
    chain_enable_in_n = 0;
  endtask
  task automatic t_errors();
    active_serial_mode = 0;
    load(3, 1);
    check(config_error_n_oe, 1);
    check(config_error_n_out, 0);
    load(2, 0);
    ext_error_low = 1;
    tick(2);
    ext_error_low = 0;
    tick(20);
    check(user_mode, 0);
    check(config_error_n_oe, 1);
  endtask
  // serial memory read-out: command bits sampled on each rising load clock
  task automatic t_serial();
    logic [7:0] got;
    logic       prev;
    got = 8'h00;
    active_serial_mode = 1;
    reconfig_request_n = 0;
    tick(2);
    reconfig_request_n = 1;
    tick(3);
    check(flash_pins_oe, 1);
    check(load_clock_oe, 1);
    check(flash_select_n, 0);
    repeat (8) begin
      do begin
        prev = load_clock;
        tick(1);
      end while (!(load_clock && !prev));
      got = {got[6:0], flash_command_out};
    end
    check(got, FLASH_READ_CMD);
    do begin
      prev = load_clock;
      tick(1);
    end while (!(load_clock && !prev));
    check(flash_command_out, 1);
  endtask
  task automatic t_chain_off();
    chain_enable_in_n = 1;
    load(3, 0);
    tick(20);
    check(load_complete_flag_oe, 1);
    chain_enable_in_n = 0;
  endtask
  task print_verdict();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst = 1;
    reconfig_request_n = 1;
    chain_enable_in_n = 0;
    {active_serial_mode, data_valid, data_last, data_error, ext_flag_low, ext_error_low} = '0;
    tick(5);
    rst = 0;
    t_normal();
    t_serial();
    t_errors();
    t_chain_off();
    print_verdict();
  end
endmodule
bind cdc_done_chain cdc_done_chain_props u_props (.*);
